// >>> mog_pkg.sv
package mog_pkg;
    // monitor source codes
    localparam logic [3:0] SEL_FREQ = 4'h0;
    localparam logic [3:0] SEL_CURR = 4'h1;
    localparam logic [3:0] SEL_FM = 4'h3;
    localparam logic [3:0] SEL_VOLT = 4'h4;
    localparam logic [3:0] SEL_POWER = 4'h5;
    localparam logic [3:0] SEL_THERM = 4'h6;
    localparam logic [3:0] SEL_RAMP = 4'h7;
    // quantity width, percent values in tenths of a percent
    localparam int QW = 16;
    localparam logic [15:0] PCT_200 = 16'h07d0;
    localparam logic [15:0] PCT_100 = 16'h03e8;
    // output levels, full-scale fraction in 16 bits
    localparam int LW = 16;
    localparam logic [15:0] LVL_MAX = 16'hffff;
    // analog current channel 4..20 mA: 4 mA is a fifth of 20 mA
    localparam logic [15:0] AMI_ZERO = 16'h3333;
    // gain unity point and defaults
    localparam logic [7:0] GAIN_UNITY = 8'hff;
    localparam logic [7:0] VGAIN_DEF = 8'hb4;
    localparam logic [7:0] IGAIN_DEF = 8'h50;
    // frequency monitor multiplier
    localparam logic [3:0] FM_MULT = 4'ha;
    // clock
    localparam int CLK_HZ = 10000000;
    localparam int PWM_PERIOD_US = 1000;
    localparam int PWM_PERIOD_CYC = CLK_HZ / 1000000 * PWM_PERIOD_US;
    localparam int PHASE_W = 32;
    localparam logic [15:0] FM_MAX_HZ = 16'h0fa0; // 4000 Hz
endpackage : mog_pkg

// >>> mog_scale.sv
`timescale 1ns/1ps
`default_nettype none
module mog_scale
    import mog_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [LW-1:0] frac_i,
    input wire logic [7:0] gain_i,
    input wire logic [LW-1:0] offset_i,
    input wire logic [LW-1:0] base_i,
    output logic [LW-1:0] level_o
);
    logic [LW-1:0] level_ff;
    logic [LW-1:0] nxt_level;
    logic [47:0] wide;
    logic [LW+1:0] sum;
    // span above base is (max - base), scaled by gain/255; wide enough for frac * span
    always_comb begin
        wide = (48'(frac_i) * 48'(gain_i)) / 48'(GAIN_UNITY);
        wide = (wide * 48'(LVL_MAX - base_i)) >> LW;
        sum = 18'(wide[LW:0]) + 18'(base_i) + 18'(offset_i);
        nxt_level = (sum > 18'(LVL_MAX)) ? LVL_MAX : sum[LW-1:0];
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            level_ff <= '0;
        end else begin
            level_ff <= nxt_level;
        end
    end
    assign level_o = level_ff;
endmodule : mog_scale
`default_nettype wire

// >>> mog_pwm.sv
`timescale 1ns/1ps
`default_nettype none
module mog_pwm
    import mog_pkg::*;
#(
    parameter int PERIOD = PWM_PERIOD_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [LW-1:0] duty_i,
    output logic pwm_o,
    output logic start_o
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [15:0] hi_ff;
    logic [15:0] nxt_hi;
    logic pwm_ff;
    logic nxt_pwm;
    logic [31:0] hi_calc;
    always_comb begin
        hi_calc = (32'(duty_i) * 32'(PERIOD) + 32'(LVL_MAX) - 32'h1) / 32'(LVL_MAX);
        nxt_cnt = (cnt_ff == 16'(PERIOD - 1)) ? 16'h0 : cnt_ff + 16'h1;
        nxt_hi = hi_ff;
        if (cnt_ff == 16'(PERIOD - 1)) begin
            nxt_hi = hi_calc[15:0]; // latch at period start
        end
        nxt_pwm = (nxt_cnt < nxt_hi);
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_ff <= 16'(PERIOD - 1);
            hi_ff <= '0;
            pwm_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            hi_ff <= nxt_hi;
            pwm_ff <= nxt_pwm;
        end
    end
    assign pwm_o = pwm_ff;
    assign start_o = (cnt_ff == 16'h0);
endmodule : mog_pwm
`default_nettype wire

// >>> mog_top.sv
// Behaviour
// - the pulse selector picks the source: 00,01,04..07 as pwm, 03 as frequency train.
// - frequencies scale to max frequency, current and power to 200%, the rest to 100%.
// - in pwm mode the value is high time over a fixed period.
// - in pwm mode an 8-bit gain 0..255 sets the full-scale level.
// - a calibration input forces the pulse output continuously high.
// - in frequency mode the train runs at ten times output frequency, at most 4 kHz.
// - the frequency train top follows the max frequency setting.
// - the frequency train is digital and ignores the pulse gain.
// - the voltage and current channels each have an independent selector.
// - voltage channel spans 0..10 V, current channel 4..20 mA over full scale.
// - each analog channel has its own gain and offset, defaults 180 and 80.
`timescale 1ns/1ps
`default_nettype none
module mog_top
    import mog_pkg::*;
#(
    parameter int PERIOD = PWM_PERIOD_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] pulse_monitor_select_i,
    input wire logic [7:0] pulse_monitor_gain_i,
    input wire logic calibrate_i,
    input wire logic [15:0] max_frequency_setting_i,
    input wire logic [3:0] voltage_monitor_select_i,
    input wire logic [3:0] current_monitor_select_i,
    input wire logic [7:0] voltage_monitor_gain_i,
    input wire logic [LW-1:0] voltage_monitor_offset_i,
    input wire logic [7:0] current_monitor_gain_i,
    input wire logic [LW-1:0] current_monitor_offset_i,
    input wire logic [15:0] out_freq_i,
    input wire logic [15:0] ramp_freq_i,
    input wire logic [QW-1:0] current_pct_i,
    input wire logic [QW-1:0] voltage_pct_i,
    input wire logic [QW-1:0] power_pct_i,
    input wire logic [QW-1:0] thermal_pct_i,
    output logic pulse_monitor_terminal_o,
    output logic [LW-1:0] voltage_monitor_terminal_o,
    output logic [LW-1:0] current_monitor_terminal_o
);
    ////////////////////////////////////////////////////////////////////////
    // normalise a quantity to a full-scale fraction
    function automatic logic [LW-1:0] norm(input logic [15:0] val, input logic [15:0] fs);
        logic [31:0] q;
        q = 32'h0;
        if (fs != 16'h0) begin
            q = ({val, 16'h0} - {16'h0, val}) / {16'h0, fs};
        end
        if (q > 32'(LVL_MAX)) begin
            q = 32'(LVL_MAX);
        end
        norm = q[LW-1:0];
    endfunction : norm

    function automatic logic [LW-1:0] pick(input logic [3:0] sel, input logic [15:0] fmax,
        input logic [15:0] f, input logic [15:0] r, input logic [15:0] c,
        input logic [15:0] v, input logic [15:0] p, input logic [15:0] t);
        case (sel)
            SEL_FREQ: pick = norm(f, fmax);
            SEL_CURR: pick = norm(c, PCT_200);
            SEL_VOLT: pick = norm(v, PCT_100);
            SEL_POWER: pick = norm(p, PCT_200);
            SEL_THERM: pick = norm(t, PCT_100);
            SEL_RAMP: pick = norm(r, fmax);
            default: pick = '0;
        endcase
    endfunction : pick

    ////////////////////////////////////////////////////////////////////////
    // source selection
    logic [LW-1:0] pulse_frac;
    logic [LW-1:0] vol_frac;
    logic [LW-1:0] cur_frac;
    always_comb begin
        pulse_frac = pick(pulse_monitor_select_i, max_frequency_setting_i, out_freq_i,
            ramp_freq_i, current_pct_i, voltage_pct_i, power_pct_i, thermal_pct_i);
        vol_frac = pick(voltage_monitor_select_i, max_frequency_setting_i, out_freq_i,
            ramp_freq_i, current_pct_i, voltage_pct_i, power_pct_i, thermal_pct_i);
        cur_frac = pick(current_monitor_select_i, max_frequency_setting_i, out_freq_i,
            ramp_freq_i, current_pct_i, voltage_pct_i, power_pct_i, thermal_pct_i);
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse monitor pwm path
    logic [LW-1:0] pwm_duty;
    logic pwm_wave;
    logic pwm_start;
    mog_scale u_pscale (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .frac_i(pulse_frac),
        .gain_i(pulse_monitor_gain_i),
        .offset_i('0),
        .base_i('0),
        .level_o(pwm_duty)
    );
    mog_pwm #(.PERIOD(PERIOD)) u_pwm (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .duty_i(pwm_duty),
        .pwm_o(pwm_wave),
        .start_o(pwm_start)
    );

    ////////////////////////////////////////////////////////////////////////
    // frequency train: phase accumulator, 10x output frequency
    logic [PHASE_W-1:0] phase_ff;
    logic [PHASE_W-1:0] nxt_phase;
    logic [15:0] fm_hz;
    logic [15:0] fm_cap;
    logic [PHASE_W-1:0] step;
    logic [31:0] tmp;
    logic [31:0] cap_wide;
    always_comb begin
        tmp = 32'(out_freq_i) * 32'(FM_MULT);
        cap_wide = 32'(max_frequency_setting_i) * 32'(FM_MULT);
        if (cap_wide > 32'(FM_MAX_HZ)) begin
            fm_cap = FM_MAX_HZ;
        end else begin
            fm_cap = cap_wide[15:0];
        end
        fm_hz = (tmp > 32'(fm_cap)) ? fm_cap : tmp[15:0];
        // step = hz * 2^32 / clk, done as a 64-bit shift by 32 then integer divide by clk
        step = PHASE_W'((64'(fm_hz) << 32) / 64'(CLK_HZ));
        nxt_phase = phase_ff + step;
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            phase_ff <= '0;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output selection
    logic pulse_ff;
    logic nxt_pulse;
    always_comb begin
        if (calibrate_i) begin
            nxt_pulse = 1'b1;
        end else if (pulse_monitor_select_i == SEL_FM) begin
            nxt_pulse = phase_ff[PHASE_W-1];
        end else begin
            nxt_pulse = pwm_wave;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= nxt_pulse;
        end
    end
    assign pulse_monitor_terminal_o = pulse_ff;

    ////////////////////////////////////////////////////////////////////////
    // analog channels, 16-bit levels of 10 V and 20 mA
    mog_scale u_vscale (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .frac_i(vol_frac),
        .gain_i(voltage_monitor_gain_i),
        .offset_i(voltage_monitor_offset_i),
        .base_i('0),
        .level_o(voltage_monitor_terminal_o)
    );
    mog_scale u_iscale (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .frac_i(cur_frac),
        .gain_i(current_monitor_gain_i),
        .offset_i(current_monitor_offset_i),
        .base_i(AMI_ZERO),
        .level_o(current_monitor_terminal_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    cal_high_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        calibrate_i |=> pulse_monitor_terminal_o)
        else $error("calibration did not force high");
    fm_src_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!calibrate_i && pulse_monitor_select_i == SEL_FM) |=> 
        pulse_monitor_terminal_o == $past(phase_ff[PHASE_W-1]))
        else $error("frequency train not routed");
    pwm_src_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (!calibrate_i && pulse_monitor_select_i != SEL_FM) |=>
        pulse_monitor_terminal_o == $past(pwm_wave))
        else $error("pwm not routed");
    fm_cap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        fm_hz <= FM_MAX_HZ && 32'(fm_hz) <= 32'(max_frequency_setting_i) * 32'(FM_MULT))
        else $error("frequency train above limit");
    zero_pwm_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (pwm_start && $past(pwm_duty) == '0 && !calibrate_i && pulse_monitor_select_i != SEL_FM)
        |=> ##1 (!pulse_monitor_terminal_o || $past(calibrate_i)
        || $past(pulse_monitor_select_i) == SEL_FM))
        else $error("zero duty gave a pulse");
    ami_floor_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(rst_i) == 1'b0 |-> current_monitor_terminal_o >= AMI_ZERO || $past(rst_i, 2))
        else $error("current channel below 4 mA");
    unk_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (pulse_monitor_select_i == 4'h2) |-> pulse_frac == '0)
        else $error("unused code gave a value");
    cur_fs_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (voltage_monitor_select_i == SEL_CURR && current_pct_i >= PCT_200) |->
        vol_frac == LVL_MAX)
        else $error("200 percent not full scale");
    cal_c: cover property (@(posedge ref_clk_i) calibrate_i);
    fm_c: cover property (@(posedge ref_clk_i) pulse_monitor_select_i == SEL_FM
        && $rose(phase_ff[PHASE_W-1]));
    pwm_c: cover property (@(posedge ref_clk_i) pwm_start && pwm_duty != '0);
endmodule : mog_top
`default_nettype wire

// >>> mog_meter.sv
`timescale 1ns/1ps
`default_nettype none
module mog_meter (
    input wire logic ref_clk_i,
    input wire logic pulse_i,
    input wire logic clear_i,
    output logic [31:0] high_cnt_o,
    output logic [31:0] period_o,
    output logic [31:0] edges_o
);
    logic [31:0] since_ff;
    logic last_ff;
    // needle integrates high time, counter input times rising-edge spacing
    always @(posedge ref_clk_i) begin
        last_ff <= pulse_i;
        if (clear_i) begin
            high_cnt_o <= 32'h0;
            period_o <= 32'h0;
            edges_o <= 32'h0;
            since_ff <= 32'h0;
        end else begin
            high_cnt_o <= high_cnt_o + {31'h0, pulse_i};
            since_ff <= since_ff + 32'h1;
            if (pulse_i && !last_ff) begin
                edges_o <= edges_o + 32'h1;
                period_o <= (edges_o != 32'h0) ? since_ff + 32'h1 : 32'h0;
                since_ff <= 32'h0;
            end
        end
    end
endmodule : mog_meter
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mog_pkg::*;
    localparam int PER = 100;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cal = 1'b0;
    logic clr = 1'b0;
    logic [3:0] psel = 4'h0, vsel = 4'h0, isel = 4'h0;
    logic [7:0] pgn = 8'hff, vgn = 8'hff, ign = 8'hff;
    logic [15:0] maxf = 16'h003c, outf = 16'h0, rmpf = 16'h0, cur = 16'h0;
    logic [15:0] vlt = 16'h0, pwr = 16'h0, thr = 16'h0, voff = 16'h0, ioff = 16'h0;
    logic pulse;
    logic [15:0] vout, iout;
    logic [31:0] hi, per, edg;
    int n_fail = 0;
    int num_checks = 0;
    int codes[6] = '{0, 1, 4, 5, 6, 7};
    int pct[6] = '{100, 50, 25, 75, 10, 20};
    ////////////////////////////////////////////////////////////////
    mog_top #(.PERIOD(PER)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .pulse_monitor_select_i(psel), .pulse_monitor_gain_i(pgn), .calibrate_i(cal),
        .max_frequency_setting_i(maxf), .voltage_monitor_select_i(vsel),
        .current_monitor_select_i(isel), .voltage_monitor_gain_i(vgn),
        .voltage_monitor_offset_i(voff), .current_monitor_gain_i(ign),
        .current_monitor_offset_i(ioff), .out_freq_i(outf), .ramp_freq_i(rmpf),
        .current_pct_i(cur), .voltage_pct_i(vlt), .power_pct_i(pwr), .thermal_pct_i(thr),
        .pulse_monitor_terminal_o(pulse), .voltage_monitor_terminal_o(vout),
        .current_monitor_terminal_o(iout));
    mog_meter meter (.ref_clk_i(ref_clk_i), .pulse_i(pulse), .clear_i(clr),
        .high_cnt_o(hi), .period_o(per), .edges_o(edg));
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp, input int tol);
        logic [31:0] d;
        num_checks++;
        d = (seen > exp) ? seen - exp : exp - seen;
        if ((^seen === 1'bx) || (d > tol)) begin
            n_fail++;
            $display("BAD %s expected %0d seen %0d", name, exp, seen);
        end
    endtask : check
    // settle past two pwm periods, then integrate one period
    task automatic measure();
        repeat (2 * PER + 5) @(negedge ref_clk_i);
        clr = 1'b1;
        @(negedge ref_clk_i);
        clr = 1'b0;
        repeat (PER) @(negedge ref_clk_i);
    endtask : measure
    task automatic fm_period(input logic [31:0] exp);
        int k;
        k = 0;
        clr = 1'b1;
        @(negedge ref_clk_i);
        clr = 1'b0;
        while (edg < 2 && k < 3 * exp + 10) begin
            @(negedge ref_clk_i);
            k++;
        end
        check("fm period", per, exp, 2);
    endtask : fm_period
    initial begin
        repeat (100000) @(posedge ref_clk_i);
        n_fail++;
        $display("BAD run length expected end seen timeout");
        conclude();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge ref_clk_i);
        check("pulse in reset", {31'h0, pulse}, 32'h0, 0);
        check("volt in reset", {16'h0, vout}, 32'h0, 0);
        rst_i = 1'b0;
        outf = 16'h003c;
        cur = 16'h03e8;
        vlt = 16'h00fa;
        pwr = 16'h05dc;
        thr = 16'h0064;
        rmpf = 16'h000c;
        // each source at a distinct fraction, channels on different codes
        for (int i = 0; i < 6; i++) begin
            psel = codes[i][3:0];
            vsel = codes[i][3:0];
            isel = codes[(i + 1) % 6][3:0];
            measure();
            check("pwm duty", hi, pct[i], 1);
            check("volt level", {16'h0, vout}, 65535 * pct[i] / 100, 8);
            check("curr level", {16'h0, iout}, 13107 + 52428 * pct[(i + 1) % 6] / 100, 8);
        end
        psel = SEL_FREQ;
        vsel = SEL_VOLT;
        isel = SEL_CURR;
        cur = 16'h07d0;
        pgn = 8'h80;
        vgn = VGAIN_DEF;
        ign = IGAIN_DEF;
        measure();
        check("pwm half gain", hi, 50, 1);
        check("volt def gain", {16'h0, vout}, 11565, 8);
        check("curr def gain", {16'h0, iout}, 29555, 8);
        pgn = 8'h00;
        vgn = 8'h00;
        voff = 16'h8000;
        ign = 8'h00;
        measure();
        check("pwm zero gain", hi, 0, 0);
        check("volt offset", {16'h0, vout}, 32768, 2);
        check("curr base", {16'h0, iout}, 13107, 2);
        vgn = 8'hff;
        vsel = SEL_CURR;
        cal = 1'b1;
        measure();
        check("calibrate high", hi, PER, 0);
        check("volt clipped", {16'h0, vout}, 65535, 0);
        cal = 1'b0;
        psel = SEL_FM;
        fm_period(16667);
        maxf = 16'h01f4;
        outf = 16'h00c8;
        fm_period(5000);
        outf = 16'h01c2;
        fm_period(2500);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
